// ### common/emif_pkg.sv
package emif_pkg;

   typedef enum logic [1:0] {
      EMIF_REG_CF,
      EMIF_REG_FLASH,
      EMIF_REG_LCD,
      EMIF_REG_FILE
   } emif_region_t;

   typedef enum logic [2:0] {
      EMIF_IDLE,
      EMIF_SETUP,
      EMIF_STROBE,
      EMIF_HOLD,
      EMIF_DONE
   } emif_state_t;

endpackage : emif_pkg

// ### common/emif_regs.svh
`ifndef EMIF_REGS_SVH
`define EMIF_REGS_SVH

// register byte offsets on the APB side
`define EMIF_OFS_ECC_RESULT_CURRENT      8'h00
`define EMIF_OFS_ECC_RESULT_HISTORY1      8'h04
`define EMIF_OFS_ECC_RESULT_HISTORY2      8'h08
`define EMIF_OFS_ECC_RESULT_HISTORY3      8'h0C
`define EMIF_OFS_ECC_CONTROL    8'h10
`define EMIF_OFS_ECC_STATUS     8'h14
`define EMIF_OFS_FLASH_SELECT_CONTROL     8'h18
`define EMIF_OFS_FLASH_READY_STATUS      8'h1C
`define EMIF_OFS_CARD_WAIT_STATES    8'h20
`define EMIF_OFS_FMWAIT    8'h24
`define EMIF_OFS_LCDWAIT   8'h28
`define EMIF_OFS_INTERFACE_SYSTEM_CONTROL    8'h2C

// ecc control fields
`define EMIF_ECC_ERST      0
`define EMIF_ECC_X16       2
`define EMIF_ECC_DIR       3
`define EMIF_ECC_EPD       4
`define EMIF_ECC_ADDRL_LO  4'h4
`define EMIF_ECC_ADDRH_LO  4'h8
`define EMIF_ECC_REGION_LO 4'hC
`define EMIF_ECC_CONTROL_RST    14'h0000

// flash control / status and system control fields
`define EMIF_FM_HOLD       0
`define EMIF_FM_SEL        1
`define EMIF_FLASH_READY_STATUS_RDY      0
`define EMIF_FLASH_READY_STATUS_WP       1
`define EMIF_SYS_WRP       0

// wait state fields
`define EMIF_W_RWCS_LO     0
`define EMIF_W_RWPW_LO     5
`define EMIF_W_RDY         11
`define EMIF_W_CSRW_LO     12
`define EMIF_WAIT_RST      16'h0000

// internal address map (byte addresses)
`define EMIF_CF_BASE       24'h020000
`define EMIF_CF_END        24'h021000
`define EMIF_FM_BASE       24'h021000
`define EMIF_FM_END        24'h021200
`define EMIF_LCD_BASE      24'h022000
`define EMIF_LCD_END       24'h022200
`define EMIF_LCD_ALIAS     24'h028000
`define EMIF_OFS_CMD       9'h002
`define EMIF_OFS_ADR       9'h004
`define EMIF_OFS_DISPLAY_REG_SELECT     9'h002

// ecc block length in bytes minus one
`define EMIF_ECC_LAST      9'h1FF

`endif

// ### tb/emif_partner.sv
`timescale 1ns/1ps
module emif_partner (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // pins from the controller
   input  wire logic [13:0] ext_addr,
   input  wire logic        rd_n,
   input  wire logic        flash_rd_n,
   input  wire logic        flash_wr_n,
   input  wire logic        nand_cle,
   // pins to the controller
   output logic      [15:0] ext_rdata,
   output logic             flash_rdy
);
   logic [5:0] busy_reg;
   // pulled-up bus reads all ones when nobody drives it
   assign ext_rdata = (!rd_n || !flash_rd_n) ? ({2'h0, ext_addr} ^ 16'hC33C) : 16'hFFFF;
   // a command write keeps the part busy for a while
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 6'h00;
      end else if (!flash_wr_n && nand_cle) begin
         busy_reg <= 6'h28;
      end else if (busy_reg != 6'h00) begin
         busy_reg <= busy_reg - 6'h01;
      end
   end
   assign flash_rdy = (busy_reg == 6'h00);
endmodule : emif_partner

// ### tb/emif_top_assertions.sv
`timescale 1ns/1ps
module emif_chk (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       wr_n,
   input wire logic       rd_n,
   input wire logic [1:0] dout_valid,
   input wire logic       mux_sel,
   input wire logic       card_select_n,
   input wire logic       display_select_n,
   input wire logic       nand_select0_n,
   input wire logic       nand_select1_n,
   input wire logic       display_reg_select,
   input wire logic       flash_wr_n,
   input wire logic       flash_rd_n,
   input wire logic       nand_cle,
   input wire logic       nand_ale
);
   logic any_cs;
   assign any_cs = !(card_select_n && display_select_n && nand_select0_n && nand_select1_n);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_one_cs;
      $onehot0({~card_select_n, ~display_select_n, ~nand_select0_n, ~nand_select1_n});
   endproperty
   property p_fwr; $fell(flash_wr_n) |-> wr_n && dout_valid == 2'h3 && any_cs; endproperty
   property p_frd; !flash_rd_n |-> !rd_n && dout_valid == 2'h0; endproperty
   property p_cle; nand_cle |-> !nand_ale && dout_valid == 2'h3 && any_cs; endproperty
   property p_ale; $rose(nand_ale) |-> $fell(nand_select0_n) || $fell(nand_select1_n); endproperty
   property p_rs; display_reg_select |-> !display_select_n && mux_sel; endproperty
   property p_mux; $fell(card_select_n) || $fell(display_select_n) |-> mux_sel; endproperty
   // an inverted cf strobe falls together with its select; that edge is no strobe start
   property p_wr;
      $fell(wr_n) && !$fell(card_select_n) |-> $past(any_cs) && dout_valid == 2'h3;
   endproperty
   property p_rd; $fell(rd_n) |-> $past(any_cs) && any_cs; endproperty
   a_one_cs: assert property (p_one_cs) else $error("two selects active");
   a_fwr: assert property (p_fwr) else $error("flash write strobe bad");
   a_frd: assert property (p_frd) else $error("flash read strobe bad");
   a_cle: assert property (p_cle) else $error("command latch bad");
   a_ale: assert property (p_ale) else $error("address latch bad");
   a_rs: assert property (p_rs) else $error("register select bad");
   a_mux: assert property (p_mux) else $error("mux select low in access");
   a_wr: assert property (p_wr) else $error("write strobe outside select");
   a_rd: assert property (p_rd) else $error("read strobe outside select");
   c_cle: cover property (nand_cle);
   c_rs: cover property (display_reg_select);
   c_frd: cover property ($fell(flash_rd_n));
endmodule : emif_chk

bind emif_top emif_chk u_emif_chk (.*);

// ### tb/test_ext_mem_if_nand_ecc.sv
`timescale 1ns/1ps
`include "emif_regs.svh"
module test_ext_mem_if_nand_ecc;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, acc_req = 1'b0, acc_write = 1'b0, acc_ack;
   logic [23:0] acc_addr = 24'h0;
   logic [15:0] acc_wdata = 16'h0, acc_rdata, ext_wdata, ext_rdata;
   logic [13:0] ext_addr, snap = 14'h0;
   logic [1:0]  dout_valid;
   logic        wr_n, rd_n, mux_sel, card_select_n, display_select_n, nand_select0_n;
   logic        nand_select1_n, display_reg_select, flash_wr_n, flash_rd_n;
   logic        nand_cle, nand_ale, flash_wp_n, flash_rdy;
   logic [32:0] pq[$];
   logic [46:0] aq[$], ea;
   int          bad_count = 0, checks_done = 0, cyc = 0, ncs = 0;
   always #2.5 clk = ~clk;
   emif_top u_emif_top (.*);
   emif_partner u_emif_partner (.*);
   task end_of_test;
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task apb_rd(input logic [7:0] a, input logic [32:0] e);
      pq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : apb_rd
   // pin picture expected at the first strobe cycle of the access
   task acc(input logic w, input logic [23:0] a, input logic [13:0] p);
      logic [15:0] d;
      d = 16'($urandom);
      aq.push_back({d, ~w, p, {2'h0, a[13:0]} ^ 16'hC33C});
      acc_req <= 1'b1;
      acc_write <= w;
      acc_addr <= a;
      acc_wdata <= d;
      do @(posedge clk); while (acc_ack !== 1'b1);
      acc_req <= 1'b0;
      @(posedge clk);
   endtask : acc
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test;
      end
   end
   always @(posedge clk) begin
      ncs = (card_select_n && display_select_n && nand_select0_n && nand_select1_n) ? 0 : ncs + 1;
      if (ncs == 2) snap = {~card_select_n, ~display_select_n, ~nand_select0_n, ~nand_select1_n,
         ~wr_n, ~rd_n, ~flash_wr_n, ~flash_rd_n, nand_cle, nand_ale, display_reg_select,
         dout_valid, mux_sel};
      if (acc_ack === 1'b1) begin
         ea = aq.pop_front();
         chk(33'(snap), 33'(ea[29:16]));
         if (ea[30]) chk(33'(acc_rdata), 33'(ea[15:0]));
         if (ea[16]) chk(33'({2'h0, ext_addr} ^ 16'hC33C), 33'(ea[15:0]));
         if (ea[17]) chk(33'(ext_wdata), 33'(ea[46:31]));
         snap = 14'h0;
      end
      if (pready === 1'b1 && !pwrite) chk({pslverr, prdata}, pq.pop_front());
   end
   initial begin
      void'($urandom(2807));
      repeat (8) @(posedge clk);
      chk(33'({flash_wp_n, wr_n, mux_sel}), 33'h2);
      rst_n <= 1'b1;
      @(posedge clk);
      apb_rd(`EMIF_OFS_CARD_WAIT_STATES, 33'h0);
      apb_rd(`EMIF_OFS_ECC_STATUS, 33'h1);
      apb_rd(`EMIF_OFS_FLASH_READY_STATUS, 33'h1);
      apb_rd(8'h30, 33'h1_0000_0000);
      // reads need a long strobe because input data is pipelined
      for (int i = 0; i < 3; i++) apb(1'b1, `EMIF_OFS_CARD_WAIT_STATES + 8'(4 * i), 32'hA0);
      apb_rd(`EMIF_OFS_LCDWAIT, 33'hA0);
      acc(1'b1, 24'h020000 + 24'($urandom & 32'hFFE), 14'h2207);
      acc(1'b0, 24'h020020, 14'h2101);
      acc(1'b1, 24'h021004, 14'h0897);
      acc(1'b0, 24'h021008, 14'h0941);
      acc(1'b1, 24'h022002, 14'h120F);
      acc(1'b0, 24'h022004, 14'h1101);
      acc(1'b1, 24'h028010, 14'h120F);
      acc(1'b1, 24'h010000, 14'h0000);
      acc(1'b1, 24'h021002, 14'h08A7);
      repeat (4) @(posedge clk);
      apb_rd(`EMIF_OFS_FLASH_READY_STATUS, 33'h0);
      repeat (50) @(posedge clk);
      apb(1'b1, `EMIF_OFS_FLASH_READY_STATUS, 32'h2);
      @(posedge clk);
      chk(33'(flash_wp_n), 33'h1);
      apb_rd(`EMIF_OFS_FLASH_READY_STATUS, 33'h3);
      apb(1'b1, `EMIF_OFS_INTERFACE_SYSTEM_CONTROL, 32'h1);
      acc(1'b1, 24'h020010, 14'h2007);
      apb(1'b1, `EMIF_OFS_INTERFACE_SYSTEM_CONTROL, 32'h0);
      apb(1'b1, `EMIF_OFS_FLASH_SELECT_CONTROL, 32'h2);
      acc(1'b1, 24'h021000, 14'h0487);
      apb(1'b1, `EMIF_OFS_FLASH_SELECT_CONTROL, 32'h1);
      @(posedge clk);
      chk(33'({nand_select0_n, nand_select1_n}), 33'h1);
      apb(1'b1, `EMIF_OFS_FLASH_SELECT_CONTROL, 32'h0);
      apb(1'b1, `EMIF_OFS_ECC_CONTROL, 32'h1F01);
      apb(1'b1, `EMIF_OFS_ECC_RESULT_CURRENT, 32'hFFFFFFFF);
      for (int i = 0; i < 4; i++) apb_rd(8'(4 * i), 33'h0);
      for (int i = 0; i < 256; i++) begin
         acc(1'b1, 24'h021100 + 24'(2 * (i % 64)), 14'h0887);
         if (i == 0) apb_rd(`EMIF_OFS_ECC_STATUS, 33'h0);
      end
      apb_rd(`EMIF_OFS_ECC_STATUS, 33'h1);
      for (int i = 1; i < 4; i++) apb_rd(8'(4 * i), 33'h0);
      apb(1'b1, `EMIF_OFS_ECC_CONTROL, 32'h1F11);
      apb_rd(`EMIF_OFS_ECC_STATUS, 33'h0);
      apb_rd(`EMIF_OFS_ECC_RESULT_CURRENT, 33'h0);
      end_of_test;
   end
endmodule : test_ext_mem_if_nand_ecc

// ### verilog/emif_top.sv
`timescale 1ns/1ps
`include "emif_regs.svh"

module emif_top (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // internal access port
   input  wire logic        acc_req,
   input  wire logic        acc_write,
   input  wire logic [23:0] acc_addr,
   input  wire logic [15:0] acc_wdata,
   output logic             acc_ack,
   output logic      [15:0] acc_rdata,
   // shared external pins
   output logic      [13:0] ext_addr,
   output logic      [15:0] ext_wdata,
   input  wire logic [15:0] ext_rdata,
   output logic             wr_n,
   output logic             rd_n,
   output logic       [1:0] dout_valid,
   output logic             mux_sel,
   // selects
   output logic             card_select_n,
   output logic             display_select_n,
   output logic             nand_select0_n,
   output logic             nand_select1_n,
   output logic             display_reg_select,
   // nand control
   output logic             flash_wr_n,
   output logic             flash_rd_n,
   output logic             nand_cle,
   output logic             nand_ale,
   output logic             flash_wp_n,
   input  wire logic        flash_rdy
);

   // one nand byte folded into a 24-bit column/line parity accumulator
   function automatic logic [23:0] ecc_step(input logic [23:0] acc,
                                            input logic [7:0]  b,
                                            input logic [8:0]  idx);
      logic [23:0] r;
      r = acc;
      r[0] = acc[0] ^ b[0] ^ b[2] ^ b[4] ^ b[6];
      r[1] = acc[1] ^ b[1] ^ b[3] ^ b[5] ^ b[7];
      r[2] = acc[2] ^ b[0] ^ b[1] ^ b[4] ^ b[5];
      r[3] = acc[3] ^ b[2] ^ b[3] ^ b[6] ^ b[7];
      r[4] = acc[4] ^ b[0] ^ b[1] ^ b[2] ^ b[3];
      r[5] = acc[5] ^ b[4] ^ b[5] ^ b[6] ^ b[7];
      if (^b) begin
         for (int i = 0; i < 9; i++) begin
            r[6 + 2 * i]     = acc[6 + 2 * i] ^ ~idx[i];
            r[6 + 2 * i + 1] = acc[6 + 2 * i + 1] ^ idx[i];
         end
      end
      return r;
   endfunction : ecc_step

   // zero in a wait field means one cycle
   function automatic logic [5:0] at_least_one(input logic [5:0] v);
      return (v == 6'h00) ? 6'h01 : v;
   endfunction : at_least_one

   // registers
   logic [23:0] ecc_hist_reg [4];
   logic [13:0] ecc_ctl_reg;
   logic        ecc_clr_reg;
   logic  [1:0] fm_ctl_reg;
   logic        fm_wp_reg;
   logic        fm_rdy_reg;
   logic [15:0] wait_reg [3];
   logic        wrp_reg;

   // transfer state
   emif_pkg::emif_state_t  state_reg;
   emif_pkg::emif_state_t  state_next;
   emif_pkg::emif_region_t rgn_reg;
   logic  [5:0] cnt_reg;
   logic  [5:0] cnt_next;
   logic        wr_reg;
   logic [23:0] addr_reg;
   logic [15:0] wdata_reg;

   // pin synchronisers
   logic  [2:0] rdy_sync_reg;
   logic [15:0] rd_s1_reg;
   logic [15:0] rd_s2_reg;
   logic [15:0] rd_s3_reg;

   // ecc engine
   logic [23:0] ecc_acc_reg;
   logic  [8:0] ecc_idx_reg;

   emif_pkg::emif_region_t req_rgn;
   logic        req_mapped;
   logic [15:0] cur_wait;
   logic        apb_wr;
   logic        apb_rd_setup;
   logic  [8:0] rgn_ofs;

   // address decode of a new request
   always_comb begin
      req_rgn    = emif_pkg::EMIF_REG_FILE;
      req_mapped = 1'b1;
      if (acc_addr >= `EMIF_CF_BASE && acc_addr < `EMIF_CF_END) begin
         req_rgn = emif_pkg::EMIF_REG_CF;
      end else if (acc_addr >= `EMIF_FM_BASE && acc_addr < `EMIF_FM_END) begin
         req_rgn = emif_pkg::EMIF_REG_FLASH;
      end else if ((acc_addr >= `EMIF_LCD_BASE && acc_addr < `EMIF_LCD_END) ||
                   acc_addr >= `EMIF_LCD_ALIAS) begin
         req_rgn = emif_pkg::EMIF_REG_LCD;
      end else begin
         req_mapped = 1'b0;
      end
   end

   always_comb begin
      case (rgn_reg)
         emif_pkg::EMIF_REG_CF:    cur_wait = wait_reg[0];
         emif_pkg::EMIF_REG_FLASH: cur_wait = wait_reg[1];
         default:                  cur_wait = wait_reg[2];
      endcase
   end

   // a request taken at this edge drives its own pins, not the previous one's
   emif_pkg::emif_region_t cyc_rgn;
   logic        cyc_wr;
   logic [23:0] cyc_addr;
   logic [15:0] cyc_wdata;
   assign cyc_rgn   = (state_reg == emif_pkg::EMIF_IDLE) ? req_rgn : rgn_reg;
   assign cyc_wr    = (state_reg == emif_pkg::EMIF_IDLE) ? acc_write : wr_reg;
   assign cyc_addr  = (state_reg == emif_pkg::EMIF_IDLE) ? acc_addr : addr_reg;
   assign cyc_wdata = (state_reg == emif_pkg::EMIF_IDLE) ? acc_wdata : wdata_reg;
   assign rgn_ofs   = cyc_addr[8:0];

   // ready pin: a change counts once stages two and three agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdy_sync_reg <= 3'h0;
         fm_rdy_reg   <= 1'b0;
      end else begin
         rdy_sync_reg <= {rdy_sync_reg[1:0], flash_rdy};
         if (rdy_sync_reg[1] == rdy_sync_reg[2]) begin
            fm_rdy_reg <= rdy_sync_reg[2];
         end
      end
   end

   // read data pins, three stages like every pin input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_s1_reg <= 16'h0000;
         rd_s2_reg <= 16'h0000;
         rd_s3_reg <= 16'h0000;
      end else begin
         rd_s1_reg <= ext_rdata;
         rd_s2_reg <= rd_s1_reg;
         rd_s3_reg <= rd_s2_reg;
      end
   end

   // access sequencer: cs lead, strobe width, cs trail from the wait register
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         emif_pkg::EMIF_IDLE: begin
            if (acc_req && req_mapped) begin
               state_next = emif_pkg::EMIF_SETUP;
               cnt_next   = 6'h01;
            end
         end
         emif_pkg::EMIF_SETUP: begin
            if (cur_wait[`EMIF_W_RDY] ||
                cnt_reg >= at_least_one({2'b00, cur_wait[`EMIF_W_CSRW_LO +: 4]})) begin
               state_next = emif_pkg::EMIF_STROBE;
               cnt_next   = 6'h01;
            end else begin
               cnt_next = cnt_reg + 6'h01;
            end
         end
         emif_pkg::EMIF_STROBE: begin
            // in handshake mode the counts are ignored and ready ends the strobe
            if (cur_wait[`EMIF_W_RDY] ? fm_rdy_reg :
                cnt_reg >= at_least_one(cur_wait[`EMIF_W_RWPW_LO +: 6])) begin
               state_next = emif_pkg::EMIF_HOLD;
               cnt_next   = 6'h01;
            end else begin
               cnt_next = cnt_reg + 6'h01;
            end
         end
         emif_pkg::EMIF_HOLD: begin
            if (cur_wait[`EMIF_W_RDY] ||
                cnt_reg >= at_least_one({1'b0, cur_wait[`EMIF_W_RWCS_LO +: 5]})) begin
               state_next = emif_pkg::EMIF_DONE;
            end else begin
               cnt_next = cnt_reg + 6'h01;
            end
         end
         emif_pkg::EMIF_DONE: begin
            state_next = emif_pkg::EMIF_IDLE;
         end
         default: begin
            state_next = emif_pkg::EMIF_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= emif_pkg::EMIF_IDLE;
         cnt_reg   <= 6'h00;
         rgn_reg   <= emif_pkg::EMIF_REG_CF;
         wr_reg    <= 1'b0;
         addr_reg  <= 24'h000000;
         wdata_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         if (state_reg == emif_pkg::EMIF_IDLE && acc_req && req_mapped) begin
            rgn_reg   <= req_rgn;
            wr_reg    <= acc_write;
            addr_reg  <= acc_addr;
            wdata_reg <= acc_wdata;
         end
      end
   end

   // answer to the internal master; unmapped requests are acked at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ack   <= 1'b0;
         acc_rdata <= 16'h0000;
      end else begin
         acc_ack <= (state_next == emif_pkg::EMIF_DONE) ||
                    (state_reg == emif_pkg::EMIF_IDLE && acc_req && !req_mapped && !acc_ack);
         if (state_reg == emif_pkg::EMIF_STROBE && state_next == emif_pkg::EMIF_HOLD &&
             !wr_reg) begin
            acc_rdata <= rd_s3_reg;
         end
      end
   end

   // pin drivers, every one straight from a flop
   logic in_cycle;
   logic in_strobe;
   logic is_flash;
   assign in_cycle  = state_next == emif_pkg::EMIF_SETUP || state_next == emif_pkg::EMIF_STROBE ||
                      state_next == emif_pkg::EMIF_HOLD;
   assign in_strobe = state_next == emif_pkg::EMIF_STROBE;
   assign is_flash  = cyc_rgn == emif_pkg::EMIF_REG_FLASH;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         card_select_n    <= 1'b1;
         display_select_n <= 1'b1;
         nand_select0_n   <= 1'b1;
         nand_select1_n   <= 1'b1;
      end else begin
         card_select_n    <= !(in_cycle && cyc_rgn == emif_pkg::EMIF_REG_CF);
         display_select_n <= !(in_cycle && cyc_rgn == emif_pkg::EMIF_REG_LCD);
         // hold keeps the selected nand chip enabled between accesses
         nand_select0_n   <= !(((in_cycle && is_flash) || fm_ctl_reg[`EMIF_FM_HOLD]) &&
                               !fm_ctl_reg[`EMIF_FM_SEL]);
         nand_select1_n   <= !(((in_cycle && is_flash) || fm_ctl_reg[`EMIF_FM_HOLD]) &&
                               fm_ctl_reg[`EMIF_FM_SEL]);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_n       <= 1'b1;
         rd_n       <= 1'b1;
         flash_wr_n <= 1'b1;
         flash_rd_n <= 1'b1;
      end else begin
         // cf with wrp set gets an active-high write strobe
         if (in_cycle && cyc_rgn == emif_pkg::EMIF_REG_CF && wrp_reg) begin
            wr_n <= in_strobe && wr_reg;
         end else begin
            wr_n <= !(in_strobe && wr_reg && !is_flash);
         end
         rd_n       <= !(in_strobe && !wr_reg);
         flash_wr_n <= !(in_strobe && wr_reg && is_flash);
         flash_rd_n <= !(in_strobe && !wr_reg && is_flash);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nand_cle           <= 1'b0;
         nand_ale           <= 1'b0;
         display_reg_select <= 1'b0;
         dout_valid         <= 2'b00;
         mux_sel            <= 1'b0;
         ext_addr           <= 14'h0000;
         ext_wdata          <= 16'h0000;
         flash_wp_n         <= 1'b0;
      end else begin
         nand_cle <= in_cycle && cyc_wr && is_flash && rgn_ofs == `EMIF_OFS_CMD;
         nand_ale <= in_cycle && cyc_wr && is_flash && rgn_ofs == `EMIF_OFS_ADR;
         display_reg_select <= in_cycle && cyc_rgn == emif_pkg::EMIF_REG_LCD &&
                               (rgn_ofs == `EMIF_OFS_DISPLAY_REG_SELECT ||
                                cyc_addr >= `EMIF_LCD_ALIAS);
         dout_valid <= {2{in_cycle && cyc_wr}};
         mux_sel    <= in_cycle;
         // address and data keep their last value outside a cycle
         if (in_cycle) begin
            ext_addr  <= cyc_addr[13:0];
            ext_wdata <= cyc_wdata;
         end
         flash_wp_n <= fm_wp_reg;
      end
   end

   // ecc engine: counts bytes of matching accesses, closes a block at 512
   logic        ecc_hit;
   logic        ecc_x8;
   logic [23:0] ecc_new;
   logic  [8:0] ecc_idx_next;
   logic        ecc_block_done;
   emif_pkg::emif_region_t ecc_rgn;
   assign ecc_rgn = emif_pkg::emif_region_t'(ecc_ctl_reg[`EMIF_ECC_REGION_LO +: 2]);
   assign ecc_x8  = ecc_ctl_reg[`EMIF_ECC_X16];
   assign ecc_hit = state_reg == emif_pkg::EMIF_DONE && !ecc_ctl_reg[`EMIF_ECC_EPD] &&
                    rgn_reg == ecc_rgn && (wr_reg != ecc_ctl_reg[`EMIF_ECC_DIR]) &&
                    addr_reg[11:8] >= ecc_ctl_reg[`EMIF_ECC_ADDRL_LO +: 4] &&
                    addr_reg[11:8] <= ecc_ctl_reg[`EMIF_ECC_ADDRH_LO +: 4];

   always_comb begin
      logic [15:0] d;
      d = wr_reg ? wdata_reg : acc_rdata;
      ecc_new = ecc_step(ecc_acc_reg, d[7:0], ecc_idx_reg);
      ecc_idx_next = ecc_idx_reg + 9'h001;
      if (!ecc_x8) begin
         ecc_new      = ecc_step(ecc_new, d[15:8], ecc_idx_reg + 9'h001);
         ecc_idx_next = ecc_idx_reg + 9'h002;
      end
      ecc_block_done = ecc_x8 ? (ecc_idx_reg == `EMIF_ECC_LAST) :
                                (ecc_idx_reg == `EMIF_ECC_LAST - 9'h001);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ecc_acc_reg <= 24'h000000;
         ecc_idx_reg <= 9'h000;
         for (int i = 0; i < 4; i++) begin
            ecc_hist_reg[i] <= 24'h000000;
         end
      end else if (ecc_clr_reg) begin
         ecc_acc_reg <= 24'h000000;
         ecc_idx_reg <= 9'h000;
         for (int i = 0; i < 4; i++) begin
            ecc_hist_reg[i] <= 24'h000000;
         end
      end else if (ecc_hit) begin
         ecc_idx_reg <= ecc_idx_next;
         if (ecc_block_done) begin
            ecc_acc_reg     <= 24'h000000;
            ecc_hist_reg[3] <= ecc_hist_reg[2];
            ecc_hist_reg[2] <= ecc_hist_reg[1];
            ecc_hist_reg[1] <= ecc_hist_reg[0];
            ecc_hist_reg[0] <= ecc_new;
         end else begin
            ecc_acc_reg <= ecc_new;
         end
      end
   end

   // apb: one-cycle access phase, pready raised from the setup cycle
   assign apb_rd_setup = psel && !penable;
   assign apb_wr       = psel && penable && pready && pwrite;

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'b00 && a <= `EMIF_OFS_INTERFACE_SYSTEM_CONTROL;
   endfunction : mapped

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ecc_ctl_reg <= `EMIF_ECC_CONTROL_RST;
         ecc_clr_reg <= 1'b0;
         fm_ctl_reg  <= 2'b00;
         fm_wp_reg   <= 1'b0;
         wrp_reg     <= 1'b0;
         for (int i = 0; i < 3; i++) begin
            wait_reg[i] <= `EMIF_WAIT_RST;
         end
      end else begin
         ecc_clr_reg <= 1'b0;
         if (apb_wr) begin
            case (paddr)
               `EMIF_OFS_ECC_CONTROL: begin
                  ecc_ctl_reg <= pwdata[13:0];
                  ecc_ctl_reg[`EMIF_ECC_ERST] <= 1'b0;
                  ecc_clr_reg <= pwdata[`EMIF_ECC_ERST];
               end
               `EMIF_OFS_FLASH_SELECT_CONTROL:   fm_ctl_reg  <= pwdata[1:0];
               `EMIF_OFS_FLASH_READY_STATUS:    fm_wp_reg   <= pwdata[`EMIF_FLASH_READY_STATUS_WP];
               `EMIF_OFS_CARD_WAIT_STATES:  wait_reg[0] <= pwdata[15:0];
               `EMIF_OFS_FMWAIT:  wait_reg[1] <= pwdata[15:0];
               `EMIF_OFS_LCDWAIT: wait_reg[2] <= pwdata[15:0];
               `EMIF_OFS_INTERFACE_SYSTEM_CONTROL:  wrp_reg     <= pwdata[`EMIF_SYS_WRP];
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_rd_setup;
         pslverr <= apb_rd_setup && !mapped(paddr);
         if (apb_rd_setup && !pwrite) begin
            case (paddr)
               `EMIF_OFS_ECC_RESULT_CURRENT:    prdata <= {8'h00, ecc_hist_reg[0]};
               `EMIF_OFS_ECC_RESULT_HISTORY1:    prdata <= {8'h00, ecc_hist_reg[1]};
               `EMIF_OFS_ECC_RESULT_HISTORY2:    prdata <= {8'h00, ecc_hist_reg[2]};
               `EMIF_OFS_ECC_RESULT_HISTORY3:    prdata <= {8'h00, ecc_hist_reg[3]};
               // ready means no block half done and not powered down
               `EMIF_OFS_ECC_STATUS:   prdata <= {31'h00000000, ecc_idx_reg == 9'h000 &&
                                             !ecc_ctl_reg[`EMIF_ECC_EPD]};
               `EMIF_OFS_FLASH_READY_STATUS:    prdata <= {30'h00000000, fm_wp_reg, fm_rdy_reg};
               `EMIF_OFS_CARD_WAIT_STATES:  prdata <= {16'h0000, wait_reg[0]};
               `EMIF_OFS_FMWAIT:  prdata <= {16'h0000, wait_reg[1]};
               `EMIF_OFS_LCDWAIT: prdata <= {16'h0000, wait_reg[2]};
               default:           prdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule : emif_top
